// file: hdl/oc_pkg.sv
// Function
// - hold 16-bit linear current limit, compare current
// - every over-current fault sets flag, alerts host
// - code 00: limit current forever, never shut down
// - code 01: limit while voltage above low limit
// - code 01: low voltage shuts down, then retries
// - code 10: limit current for programmed delay time
// - code 10: still limiting at expiry, then retry
// - code 11: shut down at once, then retry
// - retry 000: no restart, stay off until cleared
// - retry 111: restart attempts without any limit
// - retry 001: one attempt, then latch off
// - retry 010: two attempts, then latch off
// - attempt start spacing equals delay count times unit, plus one cycle
// - retry 011 to 110: three to six attempts
// - delay code n gives two to the power n units
// - unit length comes from separate configuration input
// - continuous retry stops on off, bias, fault
package oc_pkg;

   localparam logic [7:0]  CMD_THRESHOLD = 8'h46;
   localparam logic [7:0]  CMD_REACTION  = 8'h47;
   localparam logic [15:0] THRESHOLD_RST = 16'h7bff;
   localparam logic [7:0]  REACTION_RST  = 8'hc0;

   localparam int LIN_EXP_HI = 15;
   localparam int LIN_EXP_LO = 11;
   localparam int LIN_MAN_HI = 10;
   localparam int FIX_W      = 48;
   localparam logic signed [5:0] FIX_FRAC = 6'sh10;

   localparam logic [1:0] RESP_IGNORE  = 2'h0;
   localparam logic [1:0] RESP_COND    = 2'h1;
   localparam logic [1:0] RESP_DELAY   = 2'h2;
   localparam logic [1:0] RESP_DISABLE = 2'h3;

   localparam logic [2:0] RETRY_NONE    = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   // response byte: [7:6] response, [5:3] retries, [2:0] delay code
   typedef struct packed {
      logic [1:0] resp;
      logic [2:0] retries;
      logic [2:0] delay;
   } reaction_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_t;

   typedef struct packed {
      logic vout_low;
      logic off_cmd;
      logic bias_lost;
      logic other_fault;
      logic fault_clear;
   } cond_t;

   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_LIMIT,
      ST_OFF,
      ST_TRY,
      ST_TRY_OFF,
      ST_LATCHED
   } oc_state_t;

   // linear value to signed fixed point with 16 fraction bits
   function automatic logic signed [FIX_W-1:0] to_fixed(input logic [15:0] lin);
      logic signed [FIX_W-1:0] man;
      logic signed [5:0]       ex;
      logic [5:0]              sh;
      man = {{(FIX_W-11){lin[LIN_MAN_HI]}}, lin[LIN_MAN_HI:0]};
      ex  = {lin[LIN_EXP_HI], lin[LIN_EXP_HI:LIN_EXP_LO]};
      sh  = 6'(ex + FIX_FRAC);
      return man <<< sh;
   endfunction

endpackage

// file: hdl/oc_reaction_regs.sv
`timescale 1ns/1ps
module oc_reaction_regs (
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire oc_pkg::cmd_t  i_cmd,
   output logic [15:0]        o_threshold,
   output oc_pkg::reaction_t  o_reaction,
   output logic [15:0]        o_rd_data,
   output logic               o_rd_valid,
   output logic               o_rd_hit,
   output logic               o_written
);

   typedef struct packed {
      logic [15:0] threshold;
      logic [7:0]  reaction;
      logic [15:0] rd_data;
      logic        rd_valid;
      logic        rd_hit;
      logic        written;
   } regs_t;

   regs_t s_ff;
   regs_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.rd_valid = 1'b0;
      nxt_s.written  = 1'b0;
      if (i_cmd.wr) begin
         if (i_cmd.code == oc_pkg::CMD_THRESHOLD) begin
            nxt_s.threshold = i_cmd.data;
         end
         if (i_cmd.code == oc_pkg::CMD_REACTION) begin
            nxt_s.reaction = i_cmd.data[7:0];
            nxt_s.written  = 1'b1;
         end
      end else if (i_cmd.rd) begin
         nxt_s.rd_valid = 1'b1;
         nxt_s.rd_hit   = 1'b1;
         if (i_cmd.code == oc_pkg::CMD_THRESHOLD) begin
            nxt_s.rd_data = s_ff.threshold;
         end else if (i_cmd.code == oc_pkg::CMD_REACTION) begin
            nxt_s.rd_data = {8'h00, s_ff.reaction};
         end else begin
            nxt_s.rd_data = 16'h0000;
            nxt_s.rd_hit  = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_ff.threshold <= oc_pkg::THRESHOLD_RST;
         s_ff.reaction  <= oc_pkg::REACTION_RST;
         s_ff.rd_data   <= 16'h0000;
         s_ff.rd_valid  <= 1'b0;
         s_ff.rd_hit    <= 1'b0;
         s_ff.written   <= 1'b0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_threshold = s_ff.threshold;
   assign o_reaction  = oc_pkg::reaction_t'(s_ff.reaction);
   assign o_rd_data   = s_ff.rd_data;
   assign o_rd_valid  = s_ff.rd_valid;
   assign o_rd_hit    = s_ff.rd_hit;
   assign o_written   = s_ff.written;

endmodule

// file: hdl/oc_unit_timer.sv
`timescale 1ns/1ps
module oc_unit_timer (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic        i_stop,
   input  wire logic [2:0]  i_code,
   input  wire logic [15:0] i_unit_cycles,
   output logic             o_busy,
   output logic             o_done
);

   typedef struct packed {
      logic        busy;
      logic        done;
      logic [15:0] pre;
      logic [7:0]  units;
   } timer_t;

   timer_t s_ff;
   timer_t nxt_s;
   logic [15:0] unit_last;
   logic [7:0]  units_last;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      // a zero unit length would never tick, so treat it as one cycle
      unit_last  = (i_unit_cycles == 16'h0000) ? 16'h0000 : 16'(i_unit_cycles - 16'h0001);
      units_last = 8'((8'h01 << i_code) - 8'h01);
      if (i_stop) begin
         nxt_s.busy  = 1'b0;
         nxt_s.pre   = 16'h0000;
         nxt_s.units = 8'h00;
      end else if (i_start) begin
         nxt_s.busy  = 1'b1;
         nxt_s.pre   = 16'h0000;
         nxt_s.units = 8'h00;
      end else if (s_ff.busy) begin
         if (s_ff.pre >= unit_last) begin
            nxt_s.pre = 16'h0000;
            if (s_ff.units == units_last) begin
               nxt_s.busy = 1'b0;
               nxt_s.done = 1'b1;
            end else begin
               nxt_s.units = 8'(s_ff.units + 8'h01);
            end
         end else begin
            nxt_s.pre = 16'(s_ff.pre + 16'h0001);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_busy = s_ff.busy;
   assign o_done = s_ff.done;

endmodule

// file: hdl/overcurrent_fault_response.sv
`timescale 1ns/1ps
module overcurrent_fault_response (
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire oc_pkg::cmd_t  i_cmd,
   input  wire logic [15:0]   i_iout,
   input  wire oc_pkg::cond_t i_cond,
   input  wire logic [15:0]   i_unit_cycles,
   output logic               o_output_on,
   output logic               o_current_limit,
   output logic               o_fault_flag,
   output logic               o_alert,
   output logic               o_latched_off,
   output logic [2:0]         o_attempts,
   output logic [15:0]        o_threshold,
   output oc_pkg::reaction_t  o_reaction,
   output logic [15:0]        o_rd_data,
   output logic               o_rd_valid,
   output logic               o_rd_hit
);

   // current and conditions come from logic on this clock, so no synchroniser

   typedef struct packed {
      oc_pkg::oc_state_t st;
      logic [2:0]        attempts;
      logic              flag;
   } core_t;

   core_t s_ff;
   core_t nxt_s;

   logic [15:0]       threshold;
   oc_pkg::reaction_t reaction;
   logic              written;
   logic              tmr_start;
   logic              tmr_stop;
   logic              tmr_done;
   logic              over_current;
   logic              powered;
   logic              more_tries;
   logic              go_down;

   oc_reaction_regs u_regs (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_cmd       (i_cmd),
      .o_threshold (threshold),
      .o_reaction  (reaction),
      .o_rd_data   (o_rd_data),
      .o_rd_valid  (o_rd_valid),
      .o_rd_hit    (o_rd_hit),
      .o_written   (written)
   );

   oc_unit_timer u_timer (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_start       (tmr_start),
      .i_stop        (tmr_stop),
      .i_code        (reaction.delay),
      .i_unit_cycles (i_unit_cycles),
      .o_busy        (),
      .o_done        (tmr_done)
   );

   // both sides go to fixed point so differing exponents compare correctly
   assign over_current = oc_pkg::to_fixed(i_iout) > oc_pkg::to_fixed(threshold);

   assign powered = (s_ff.st == oc_pkg::ST_NORMAL) || (s_ff.st == oc_pkg::ST_LIMIT) ||
                    (s_ff.st == oc_pkg::ST_TRY);

   // counter wraps under continuous retry, which is harmless there
   assign more_tries = (reaction.retries == oc_pkg::RETRY_FOREVER) ||
                       (s_ff.attempts < reaction.retries);

   always_comb begin
      nxt_s     = s_ff;
      tmr_start = 1'b0;
      tmr_stop  = 1'b0;
      go_down   = 1'b0;
      // a new fault beats a clear in the same cycle
      nxt_s.flag = (s_ff.flag & ~i_cond.fault_clear) | (over_current & powered);
      if (i_cond.fault_clear || written) begin
         nxt_s.st       = oc_pkg::ST_NORMAL;
         nxt_s.attempts = 3'h0;
         tmr_stop       = 1'b1;
      end else if ((i_cond.bias_lost || i_cond.other_fault) &&
                   (s_ff.st == oc_pkg::ST_OFF || s_ff.st == oc_pkg::ST_TRY ||
                    s_ff.st == oc_pkg::ST_TRY_OFF)) begin
         nxt_s.st = oc_pkg::ST_LATCHED;
         tmr_stop = 1'b1;
      end else if (i_cond.off_cmd && s_ff.st != oc_pkg::ST_LATCHED) begin
         nxt_s.st       = oc_pkg::ST_NORMAL;
         nxt_s.attempts = 3'h0;
         tmr_stop       = 1'b1;
      end else begin
         case (s_ff.st)
            oc_pkg::ST_NORMAL: begin
               if (over_current) begin
                  case (reaction.resp)
                     oc_pkg::RESP_IGNORE: nxt_s.st = oc_pkg::ST_LIMIT;
                     oc_pkg::RESP_COND: nxt_s.st = oc_pkg::ST_LIMIT;
                     oc_pkg::RESP_DELAY: begin
                        nxt_s.st  = oc_pkg::ST_LIMIT;
                        tmr_start = 1'b1;
                     end
                     default: go_down = 1'b1;
                  endcase
               end
            end
            oc_pkg::ST_LIMIT: begin
               if (reaction.resp == oc_pkg::RESP_DELAY) begin
                  if (tmr_done) begin
                     if (over_current) begin
                        go_down = 1'b1;
                     end else begin
                        nxt_s.st = oc_pkg::ST_NORMAL;
                     end
                  end
               end else if (reaction.resp == oc_pkg::RESP_COND && i_cond.vout_low) begin
                  go_down = 1'b1;
               end else if (reaction.resp == oc_pkg::RESP_DISABLE) begin
                  go_down = 1'b1;
               end else if (!over_current) begin
                  nxt_s.st = oc_pkg::ST_NORMAL;
               end
            end
            oc_pkg::ST_OFF: begin
               if (tmr_done) begin
                  nxt_s.st       = oc_pkg::ST_TRY;
                  nxt_s.attempts = 3'(s_ff.attempts + 3'h1);
                  tmr_start      = 1'b1;
               end
            end
            oc_pkg::ST_TRY: begin
               if (over_current) begin
                  nxt_s.st = oc_pkg::ST_TRY_OFF;
               end else if (tmr_done) begin
                  nxt_s.st       = oc_pkg::ST_NORMAL;
                  nxt_s.attempts = 3'h0;
               end
            end
            oc_pkg::ST_TRY_OFF: begin
               // output stays off for the rest of the interval before the next try
               if (tmr_done) begin
                  if (more_tries) begin
                     nxt_s.st       = oc_pkg::ST_TRY;
                     nxt_s.attempts = 3'(s_ff.attempts + 3'h1);
                     tmr_start      = 1'b1;
                  end else begin
                     nxt_s.st = oc_pkg::ST_LATCHED;
                  end
               end
            end
            oc_pkg::ST_LATCHED: nxt_s.st = oc_pkg::ST_LATCHED;
            default: nxt_s.st = oc_pkg::ST_NORMAL;
         endcase
         if (go_down) begin
            if (reaction.retries == oc_pkg::RETRY_NONE) begin
               nxt_s.st = oc_pkg::ST_LATCHED;
            end else begin
               nxt_s.st  = oc_pkg::ST_OFF;
               tmr_start = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_ff.st       <= oc_pkg::ST_NORMAL;
         s_ff.attempts <= 3'h0;
         s_ff.flag     <= 1'b0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_output_on     = powered & ~i_cond.off_cmd;
   assign o_current_limit = (s_ff.st == oc_pkg::ST_LIMIT);
   assign o_fault_flag    = s_ff.flag;
   assign o_alert         = s_ff.flag;
   assign o_latched_off   = (s_ff.st == oc_pkg::ST_LATCHED);
   assign o_attempts      = s_ff.attempts;
   assign o_threshold     = threshold;
   assign o_reaction      = reaction;

endmodule

// file: tb/oc_host_model.sv
`timescale 1ns/1ps
module oc_host_model (
   input  wire logic        i_clk,
   input  wire logic        i_rd_valid,
   input  wire logic [15:0] i_rd_data,
   input  wire logic        i_rd_hit,
   output oc_pkg::cmd_t     o_cmd
);
   initial o_cmd = '0;
   // one-cycle strobe; idle code and data are scrambled so stale values never help
   task automatic put(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge i_clk);
      #1;
      o_cmd = '{wr: w, rd: !w, code: c, data: d};
      @(posedge i_clk);
      #1;
      o_cmd = '{wr: 1'b0, rd: 1'b0, code: ~c, data: ~d};
   endtask
   task automatic write(input logic [7:0] c, input logic [15:0] d);
      put(1'b1, c, d);
   endtask
   task automatic read(input logic [7:0] c, output logic [15:0] d, output logic h);
      put(1'b0, c, {c, ~c});
      d = i_rd_data;
      h = i_rd_valid ? i_rd_hit : 1'bx;
   endtask
endmodule

// file: tb/overcurrent_fault_response_chk.sv
`timescale 1ns/1ps
module oc_resp_chk (
   input wire logic              i_clk,
   input wire logic              i_rst,
   input wire oc_pkg::cmd_t      i_cmd,
   input wire oc_pkg::cond_t     i_cond,
   input wire logic [15:0]       i_unit_cycles,
   input wire logic              o_output_on,
   input wire logic              o_current_limit,
   input wire logic              o_fault_flag,
   input wire logic              o_alert,
   input wire logic              o_latched_off,
   input wire logic [2:0]        o_attempts,
   input wire logic [15:0]       o_threshold,
   input wire oc_pkg::reaction_t o_reaction,
   input wire logic [15:0]       o_rd_data,
   input wire logic              o_rd_valid,
   input wire logic              o_rd_hit
);
   logic [2:0]  prev_ff;
   logic [23:0] gap_ff;
   logic        wrx_ff;
   logic        wrx;
   logic [23:0] span;
   assign wrx  = i_cmd.wr && i_cmd.code == oc_pkg::CMD_REACTION;
   assign span = ({8'h0, (i_unit_cycles == 16'h0) ? 16'h1 : i_unit_cycles}
                  << o_reaction.delay) + 24'h1;
   // cycles since the attempt count last moved
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_ff <= 3'h0;
         gap_ff  <= 24'h0;
         wrx_ff  <= 1'b0;
      end else begin
         prev_ff <= o_attempts;
         gap_ff  <= (o_attempts != prev_ff) ? 24'h1 : gap_ff + 24'h1;
         wrx_ff  <= wrx;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_thr_answer;
      o_rd_valid && o_rd_hit && o_rd_data == o_threshold;
   endsequence
   AST_THR_WRITE: assert property (
      i_cmd.wr && i_cmd.code == oc_pkg::CMD_THRESHOLD |=> o_threshold == $past(i_cmd.data))
      else $error("threshold write lost");
   AST_THR_READ: assert property (
      i_cmd.rd && !i_cmd.wr && i_cmd.code == oc_pkg::CMD_THRESHOLD |=> s_thr_answer)
      else $error("threshold read wrong");
   AST_ALERT: assert property (o_alert == o_fault_flag)
      else $error("alert differs from flag");
   AST_FLAG_HOLD: assert property (o_fault_flag && !i_cond.fault_clear |=> o_fault_flag)
      else $error("fault flag dropped");
   AST_IGNORE_RUNS: assert property (
      o_reaction.resp == oc_pkg::RESP_IGNORE && $past(o_reaction.resp, 2) == oc_pkg::RESP_IGNORE
      && !i_cond.off_cmd |-> o_output_on && !o_latched_off)
      else $error("ignore mode shut down");
   AST_DISABLE_NOW: assert property (
      $rose(o_fault_flag) && o_reaction.resp == oc_pkg::RESP_DISABLE
      && $past(o_reaction.resp, 2) == oc_pkg::RESP_DISABLE && !$past(i_cond.fault_clear)
      && !$past(i_cond.off_cmd) |-> !o_output_on && !o_current_limit)
      else $error("disable mode kept running");
   AST_LATCH_HOLD: assert property (
      o_latched_off && !i_cond.fault_clear && !wrx && !wrx_ff |=> o_latched_off)
      else $error("latched output left latch");
   AST_LATCH_OFF: assert property (o_latched_off |-> !o_output_on && !o_current_limit)
      else $error("latched output still on");
   AST_TRY_BOUND: assert property (
      o_reaction.retries != oc_pkg::RETRY_FOREVER
      && $past(o_reaction.retries, 2) == o_reaction.retries |-> o_attempts <= o_reaction.retries)
      else $error("too many restart attempts");
   AST_TRY_SPACING: assert property (
      o_attempts == prev_ff + 3'h1 && prev_ff != 3'h0 && o_attempts != 3'h0 |-> gap_ff == span)
      else $error("restart spacing wrong");
endmodule
bind overcurrent_fault_response oc_resp_chk u_chk (
   .i_clk, .i_rst, .i_cmd, .i_cond, .i_unit_cycles, .o_output_on, .o_current_limit,
   .o_fault_flag, .o_alert, .o_latched_off, .o_attempts, .o_threshold, .o_reaction,
   .o_rd_data, .o_rd_valid, .o_rd_hit
);

// file: tb/tb_overcurrent_fault_response.sv
`timescale 1ns/1ps
module tb_overcurrent_fault_response;
   localparam logic [1:0]  DIS  = oc_pkg::RESP_DISABLE;
   localparam logic [15:0] OVER = 16'h03ff;
   logic              i_clk = 1'b0;
   logic              i_rst = 1'b1;
   oc_pkg::cmd_t      i_cmd;
   logic [15:0]       i_iout = 16'h0;
   oc_pkg::cond_t     i_cond = '0;
   logic [15:0]       i_unit_cycles = 16'h2;
   logic              o_output_on, o_current_limit, o_fault_flag, o_alert, o_latched_off;
   logic [2:0]        o_attempts;
   logic [15:0]       o_threshold, o_rd_data, thr, rd_d;
   oc_pkg::reaction_t o_reaction;
   logic              o_rd_valid, o_rd_hit, rd_h, any_oc;
   int                n_mismatch = 0;
   int                check_count = 0;
   int                seed = 32'ha626b97e;
   int                n, t;
   always #4 i_clk = ~i_clk;
   overcurrent_fault_response u_dut (
      .i_clk, .i_rst, .i_cmd, .i_iout, .i_cond, .i_unit_cycles, .o_output_on,
      .o_current_limit, .o_fault_flag, .o_alert, .o_latched_off, .o_attempts,
      .o_threshold, .o_reaction, .o_rd_data, .o_rd_valid, .o_rd_hit
   );
   oc_host_model u_host (
      .i_clk, .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .i_rd_hit(o_rd_hit), .o_cmd(i_cmd)
   );
   // both values carry exponent 0, so the mantissas compare directly
   function automatic logic over(input logic [15:0] a, input logic [15:0] b);
      return $signed(a[10:0]) > $signed(b[10:0]);
   endfunction
   function automatic int span(input logic [15:0] u, input int d);
      return ((u == 16'h0 ? 1 : int'(u)) << d) + 1;
   endfunction
   task automatic chk_b(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic set_rx(input logic [1:0] rs, input logic [2:0] rt, input logic [2:0] d);
      u_host.write(oc_pkg::CMD_REACTION, {8'h0, rs, rt, d});
      cyc(2);
   endtask
   task automatic clr();
      i_iout = 16'h0;
      i_cond = '0;
      i_cond.fault_clear = 1'b1;
      cyc(1);
      i_cond.fault_clear = 1'b0;
      cyc(1);
   endtask
   // whole run is under a thousand cycles; this leaves a wide margin
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      chk_v("threshold", oc_pkg::THRESHOLD_RST, o_threshold);
      chk_v("reaction", {8'h0, oc_pkg::REACTION_RST}, {8'h0, o_reaction});
      u_host.read(8'h99, rd_d, rd_h);
      chk_b("unmapped hit", 1'b0, rd_h);
      thr = {7'h0, 9'($random(seed))} | 16'h0010;
      u_host.write(oc_pkg::CMD_THRESHOLD, thr);
      u_host.read(oc_pkg::CMD_THRESHOLD, rd_d, rd_h);
      chk_v("threshold read", thr, rd_d);
      chk_b("threshold hit", 1'b1, rd_h);
      set_rx(oc_pkg::RESP_IGNORE, 3'h0, 3'h0);
      any_oc = 1'b0;
      repeat (40) begin
         i_iout = {6'h0, 10'($random(seed))};
         any_oc |= over(i_iout, thr);
         cyc(1);
         chk_b("limit", over(i_iout, thr), o_current_limit);
         chk_b("output on", 1'b1, o_output_on);
      end
      chk_b("flag", any_oc, o_fault_flag);
      chk_b("alert", any_oc, o_alert);
      clr();
      chk_b("flag cleared", 1'b0, o_fault_flag);
      set_rx(DIS, oc_pkg::RETRY_NONE, 3'h0);
      i_iout = OVER;
      cyc(1);
      chk_b("output on", 1'b0, o_output_on);
      cyc(30);
      chk_b("latched", 1'b1, o_latched_off);
      chk_v("attempts", 16'h0, {13'h0, o_attempts});
      clr();
      chk_b("output on", 1'b1, o_output_on);
      for (int r = 1; r < 7; r++) begin
         // zero is included on purpose: the design must treat it as one cycle
         i_unit_cycles = 16'($random(seed) & 3);
         set_rx(DIS, 3'(r), 3'(r % 2));
         i_iout = OVER;
         n = 0;
         while (o_latched_off !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
         end
         chk_v("attempts", 16'(r), {13'h0, o_attempts});
         chk_v("latch time", 16'((r + 1) * span(i_unit_cycles, r % 2) + 1), 16'(n));
         clr();
      end
      for (int k = 0; k < 3; k++) begin
         set_rx(DIS, oc_pkg::RETRY_FOREVER, 3'h0);
         i_iout = OVER;
         cyc(150);
         chk_b("latched", 1'b0, o_latched_off);
         i_cond = oc_pkg::cond_t'(5'h08 >> k);
         cyc(3);
         chk_b("latched", k != 0, o_latched_off);
         chk_b("output on", 1'b0, o_output_on);
         clr();
         chk_b("output on", 1'b1, o_output_on);
      end
      set_rx(oc_pkg::RESP_COND, oc_pkg::RETRY_NONE, 3'h0);
      i_iout = OVER;
      cyc(20);
      chk_b("limit", 1'b1, o_current_limit);
      chk_b("output on", 1'b1, o_output_on);
      i_cond.vout_low = 1'b1;
      cyc(2);
      chk_b("latched", 1'b1, o_latched_off);
      clr();
      t = span(i_unit_cycles, 2) - 1;
      set_rx(oc_pkg::RESP_DELAY, oc_pkg::RETRY_NONE, 3'h2);
      i_iout = OVER;
      cyc(t);
      chk_b("limit", 1'b1, o_current_limit);
      cyc(2);
      chk_b("latched", 1'b1, o_latched_off);
      clr();
      i_iout = OVER;
      cyc(2);
      i_iout = 16'h0;
      cyc(t + 2);
      chk_b("latched", 1'b0, o_latched_off);
      chk_b("limit", 1'b0, o_current_limit);
      i_unit_cycles = 16'h4;
      set_rx(DIS, 3'h2, 3'h3);
      i_iout = OVER;
      n = 0;
      while ((o_attempts !== 3'h1 || o_output_on !== 1'b0) && n < 300) begin
         cyc(1);
         n++;
      end
      i_iout = 16'h0;
      set_rx(DIS, 3'h2, 3'h3);
      chk_v("attempts", 16'h0, {13'h0, o_attempts});
      chk_b("output on", 1'b1, o_output_on);
      u_host.read(oc_pkg::CMD_REACTION, rd_d, rd_h);
      chk_v("reaction read", {8'h0, DIS, 3'h2, 3'h3}, rd_d);
      chk_b("reaction hit", 1'b1, rd_h);
      finish_test();
   end
endmodule
